// ===== dsspc_defs.svh
// Constants, field positions and reset values of the synthesizer control
`ifndef DSSPC_DEFS_SVH
`define DSSPC_DEFS_SVH
`define DSSPC_RT_FIRST   1
`define DSSPC_RT_SECOND  0
`define DSSPC_RATIO_MSB  16
`define DSSPC_RATIO_LSB  2
`define DSSPC_POL_BIT    17
`define DSSPC_CUR_BIT    18
`define DSSPC_HIZ_BIT    19
`define DSSPC_LSEL_BIT   20
`define DSSPC_FSEL_BIT   21
`define DSSPC_A_MSB      8
`define DSSPC_A_LSB      2
`define DSSPC_B_MSB      19
`define DSSPC_B_LSB      9
`define DSSPC_MOD_BIT    20
`define DSSPC_PWDN_BIT   21
`define DSSPC_MOD_LOW    8'h40
`define DSSPC_MOD_HIGH   8'h80
`define DSSPC_RST_RATIO  15'h0003
`define DSSPC_RST_MAIN   11'h003
`define DSSPC_RST_CTRL   1'h1
`define DSSPC_ADDR_CTRL  12'h000
`define DSSPC_ADDR_STAT  12'h004
`define DSSPC_ADDR_WORD  12'h008
`define DSSPC_LVL_LOW    2'h0
`define DSSPC_LVL_HIGH   2'h1
`define DSSPC_LVL_FAST   2'h2
`define DSSPC_CLK_NS     8
`define DSSPC_LOCK_NS    40
`define DSSPC_LOCK_CYC   (`DSSPC_LOCK_NS / `DSSPC_CLK_NS)
`define DSSPC_LOCK_CNT   3'h4
`endif

// ===== dsspc_pkg.sv
// Types shared by the synthesizer control modules
`default_nettype none
package dsspc_pkg;
  typedef enum logic [2:0] {
    PD_ACTIVE = 3'h1,
    PD_PEND   = 3'h2,
    PD_DOWN   = 3'h4
  } dsspc_pd_e;
  typedef struct packed {
    logic [14:0] ratio;
    logic        pol;
    logic        cur;
    logic        hiz;
    logic        lsel;
    logic        fsel;
    logic [6:0]  swal;
    logic [10:0] main;
    logic        big;
    logic        pwdn;
  } dsspc_cfg_s;
endpackage : dsspc_pkg
`default_nettype wire

// ===== dsspc_loop.sv
// One synthesizer loop: dividers, phase detector and lock detector
`timescale 1ns/1ps
`default_nettype none
`include "dsspc_defs.svh"
module dsspc_loop #(
  parameter int         RW = 15,
  parameter int         BW = 11,
  parameter int         AW = 7,
  parameter logic [7:0] LW = 8'h05,
  parameter logic [2:0] LC = 3'h4
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          ref_edge,
  input  wire logic          vco_edge,
  input  wire logic          hold,
  input  wire logic          pol,
  input  wire logic          big_mod,
  input  wire logic [RW-1:0] ratio,
  input  wire logic [BW-1:0] main_cnt,
  input  wire logic [AW-1:0] swal_cnt,
  output logic               ref_pulse,
  output logic               fb_pulse,
  output logic               up,
  output logic               dn,
  output logic               locked
);
  logic [RW-1:0] r_reg, r_next;
  logic [BW-1:0] b_reg, b_next;
  logic [AW-1:0] a_reg, a_next;
  logic [7:0]    p_reg, p_next, w_reg, w_next, modv;
  logic [2:0]    g_reg, g_next;
  logic          rp_next, fp_next, up_next, dn_next, eu, ed;

  always_comb begin
    modv = (big_mod ? `DSSPC_MOD_HIGH : `DSSPC_MOD_LOW)
           + {7'h00, a_reg != '0};
    r_next = r_reg;
    b_next = b_reg;
    a_next = a_reg;
    p_next = p_reg;
    rp_next = 1'b0;
    fp_next = 1'b0;
    eu = pol ? ref_pulse : fb_pulse;
    ed = pol ? fb_pulse : ref_pulse;
    up_next = up | eu;
    dn_next = dn | ed;
    if (up_next && dn_next) begin
      up_next = 1'b0;
      dn_next = 1'b0;
    end
    w_next = w_reg;
    g_next = g_reg;
    if (up || dn) begin
      w_next = (w_reg == 8'hFF) ? w_reg : w_reg + 8'h01;
    end
    if (ref_pulse) begin
      w_next = 8'h00;
      if (w_reg < LW) begin
        g_next = (g_reg == LC) ? g_reg : g_reg + 3'h1;
      end else begin
        g_next = 3'h0;
      end
    end
    if (hold) begin
      // Preset together so N restarts aligned to R on release
      r_next = ratio;
      b_next = main_cnt;
      a_next = swal_cnt;
      p_next = 8'h00;
      up_next = 1'b0;
      dn_next = 1'b0;
      w_next = 8'h00;
      g_next = 3'h0;
    end else begin
      if (ref_edge) begin
        if (r_reg <= RW'(1)) begin
          r_next = ratio;
          rp_next = 1'b1;
        end else begin
          r_next = r_reg - RW'(1);
        end
      end
      if (vco_edge) begin
        if (p_reg >= modv - 8'h01) begin
          p_next = 8'h00;
          if (b_reg <= BW'(1)) begin
            b_next = main_cnt;
            a_next = swal_cnt;
            fp_next = 1'b1;
          end else begin
            b_next = b_reg - BW'(1);
            if (a_reg != '0) begin
              a_next = a_reg - AW'(1);
            end
          end
        end else begin
          p_next = p_reg + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= RW'(3);
      b_reg <= BW'(3);
      a_reg <= '0;
      p_reg <= 8'h00;
      w_reg <= 8'h00;
      g_reg <= 3'h0;
      ref_pulse <= 1'b0;
      fb_pulse <= 1'b0;
      up <= 1'b0;
      dn <= 1'b0;
    end else if (ce) begin
      r_reg <= r_next;
      b_reg <= b_next;
      a_reg <= a_next;
      p_reg <= p_next;
      w_reg <= w_next;
      g_reg <= g_next;
      ref_pulse <= rp_next;
      fb_pulse <= fp_next;
      up <= up_next;
      dn <= dn_next;
    end
  end

  assign locked = (g_reg == LC);
endmodule : dsspc_loop
`default_nettype wire

// ===== dsspc_top.sv
// Serial programming link, latches, powerdown and status pin control
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dsspc_defs.svh"
module dsspc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        ser_data,
  input  wire logic        ser_clk,
  input  wire logic        load_strobe,
  input  wire logic        reference_input,
  input  wire logic [1:0]  vco_in,
  input  wire logic        status_mux_pin_in,
  output logic             status_mux_pin_out,
  output logic             status_mux_pin_oe,
  output logic [1:0]       pump_up,
  output logic [1:0]       pump_dn,
  output logic [1:0]       pump_hiz,
  output logic [1:0][1:0]  pump_current_level,
  output logic [1:0]       rf_in_hiz,
  output logic             osc_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  // Pin synchroniser: bit 0 data, 1 clock, 2 strobe, 3 ref, 4-5 vco, 6 pin
  logic [6:0] pins, meta_reg, sync_reg, last_reg, rise;
  assign pins = {status_mux_pin_in, vco_in, reference_input,
                 load_strobe, ser_clk, ser_data};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 7'h00;
      sync_reg <= 7'h00;
      last_reg <= 7'h00;
    end else if (ce) begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign rise = sync_reg & ~last_reg;

  // Shift register and latches
  logic [21:0] sr_reg, sr_next, word_reg, word_next;
  dsspc_pkg::dsspc_cfg_s cfg_reg [2];
  dsspc_pkg::dsspc_cfg_s cfg_next [2];
  logic ctrl_reg, ctrl_next, ld_pulse, idx;
  // Software may gate strobes off to freeze settings while reprogramming
  assign ld_pulse = rise[2] & ctrl_reg;
  assign idx = ~sr_reg[`DSSPC_RT_SECOND];

  always_comb begin
    sr_next = sr_reg;
    word_next = word_reg;
    cfg_next = cfg_reg;
    if (rise[1]) begin
      sr_next = {sr_reg[20:0], sync_reg[0]};
    end
    if (ld_pulse) begin
      word_next = sr_reg;
      if (!sr_reg[`DSSPC_RT_FIRST]) begin
        cfg_next[idx].ratio =
          sr_reg[`DSSPC_RATIO_MSB:`DSSPC_RATIO_LSB];
        cfg_next[idx].pol  = sr_reg[`DSSPC_POL_BIT];
        cfg_next[idx].cur  = sr_reg[`DSSPC_CUR_BIT];
        cfg_next[idx].hiz  = sr_reg[`DSSPC_HIZ_BIT];
        cfg_next[idx].lsel = sr_reg[`DSSPC_LSEL_BIT];
        cfg_next[idx].fsel = sr_reg[`DSSPC_FSEL_BIT];
      end else begin
        cfg_next[idx].swal = sr_reg[`DSSPC_A_MSB:`DSSPC_A_LSB];
        cfg_next[idx].main = sr_reg[`DSSPC_B_MSB:`DSSPC_B_LSB];
        cfg_next[idx].big  = sr_reg[`DSSPC_MOD_BIT];
        cfg_next[idx].pwdn = sr_reg[`DSSPC_PWDN_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_reg <= 22'h000000;
      word_reg <= 22'h000000;
      for (int i = 0; i < 2; i++) begin
        cfg_reg[i] <= '{ratio: `DSSPC_RST_RATIO, main: `DSSPC_RST_MAIN,
                        default: '0};
      end
    end else if (ce) begin
      sr_reg <= sr_next;
      word_reg <= word_next;
      cfg_reg <= cfg_next;
    end
  end

  sequence s_ld_first_ref;
    ld_pulse && sr_reg[1:0] == 2'b01;
  endsequence
  sequence s_ld_second_fb;
    ld_pulse && sr_reg[1:0] == 2'b10;
  endsequence
  AST_RWORD: assert property (
    s_ld_first_ref |=> cfg_reg[0].ratio == word_reg[16:2]
                       && cfg_reg[0].fsel == word_reg[21])
    else $error("first loop reference latch not loaded");
  AST_NWORD: assert property (
    s_ld_second_fb |=> cfg_reg[1].main == word_reg[19:9]
                       && cfg_reg[1].swal == word_reg[8:2])
    else $error("second loop feedback latch not loaded");
  AST_SHIFT: assert property (
    rise[1] |=> sr_reg[0] == $past(sync_reg[0])
                && sr_reg[21:1] == $past(sr_reg[20:0]))
    else $error("serial bit not shifted in");

  // Loops
  logic [1:0] refp, fbp, up, dn, lock, hold, hiz, rst, down, lk;
  for (genvar g = 0; g < 2; g++) begin : g_loop
    dsspc_loop #(
      .LW (8'(`DSSPC_LOCK_CYC)),
      .LC (`DSSPC_LOCK_CNT)
    ) u_loop (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (ce),
      .ref_edge  (rise[3] & osc_enable),
      .vco_edge  (rise[4+g]),
      .hold      (hold[g]),
      .pol       (cfg_reg[g].pol),
      .big_mod   (cfg_reg[g].big),
      .ratio     (cfg_reg[g].ratio),
      .main_cnt  (cfg_reg[g].main),
      .swal_cnt  (cfg_reg[g].swal),
      .ref_pulse (refp[g]),
      .fb_pulse  (fbp[g]),
      .up        (up[g]),
      .dn        (dn[g]),
      .locked    (lock[g])
    );
  end

  // Powerdown state per loop
  dsspc_pkg::dsspc_pd_e pd_reg [2];
  dsspc_pkg::dsspc_pd_e pd_next [2];
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pd_next[i] = pd_reg[i];
      case (pd_reg[i])
        dsspc_pkg::PD_ACTIVE: pd_next[i] = dsspc_pkg::PD_ACTIVE;
        dsspc_pkg::PD_PEND: begin
          // Wait for an idle pump so the VCO does not jump
          if (!up[i] && !dn[i]) begin
            pd_next[i] = dsspc_pkg::PD_DOWN;
          end
        end
        dsspc_pkg::PD_DOWN: pd_next[i] = dsspc_pkg::PD_DOWN;
        default: pd_next[i] = dsspc_pkg::PD_ACTIVE;
      endcase
      if (ld_pulse && sr_reg[`DSSPC_RT_FIRST] && idx == 1'(i)) begin
        if (!sr_reg[`DSSPC_PWDN_BIT]) begin
          pd_next[i] = dsspc_pkg::PD_ACTIVE;
        end else if (cfg_reg[i].hiz
                     || pd_reg[i] == dsspc_pkg::PD_DOWN) begin
          pd_next[i] = dsspc_pkg::PD_DOWN;
        end else begin
          pd_next[i] = dsspc_pkg::PD_PEND;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_reg[0] <= dsspc_pkg::PD_ACTIVE;
      pd_reg[1] <= dsspc_pkg::PD_ACTIVE;
    end else if (ce) begin
      pd_reg <= pd_next;
    end
  end

  AST_ASYNC_PD: assert property (
    ld_pulse && sr_reg[1:0] == 2'b11 && sr_reg[21] && cfg_reg[0].hiz
    |=> pd_reg[0] == dsspc_pkg::PD_DOWN ##1 rf_in_hiz[0])
    else $error("immediate powerdown not taken");
  AST_SYNC_PD: assert property (
    pd_reg[0] == dsspc_pkg::PD_PEND && (up[0] || dn[0]) && !ld_pulse
    |=> pd_reg[0] == dsspc_pkg::PD_PEND)
    else $error("powerdown while pump active");
  AST_WAKE: assert property (
    ld_pulse && sr_reg[1:0] == 2'b11 && !sr_reg[21]
    |=> pd_reg[0] == dsspc_pkg::PD_ACTIVE ##1 !rf_in_hiz[0])
    else $error("loop did not wake on zero powerdown");

  // Status pin and pump controls
  logic [1:0] fs, ls;
  logic fast, pin_out_next, pin_oe_next;
  logic [1:0] up_next, dn_next;
  logic [1:0][1:0] lvl_next;
  always_comb begin
    fs = {cfg_reg[0].fsel, cfg_reg[1].fsel};
    ls = {cfg_reg[0].lsel, cfg_reg[1].lsel};
    fast = (fs == 2'b11) && (ls == 2'b00);
    for (int i = 0; i < 2; i++) begin
      rst[i] = (fs == 2'b11) && cfg_reg[i].lsel;
      down[i] = pd_reg[i][2];
      hold[i] = down[i] | rst[i];
      hiz[i] = cfg_reg[i].hiz | rst[i] | down[i];
      up_next[i] = up[i] & ~hiz[i];
      dn_next[i] = dn[i] & ~hiz[i];
      lk[i] = lock[i] & ~(up[i] | dn[i]);
      if (fast && cfg_reg[i].cur) begin
        lvl_next[i] = `DSSPC_LVL_FAST;
      end else if (cfg_reg[i].cur) begin
        lvl_next[i] = `DSSPC_LVL_HIGH;
      end else begin
        lvl_next[i] = `DSSPC_LVL_LOW;
      end
    end
    pin_out_next = 1'b0;
    pin_oe_next = 1'b1;
    case (fs)
      2'b00: begin
        case (ls)
          2'b01: pin_out_next = lk[1];
          2'b10: pin_out_next = lk[0];
          2'b11: pin_out_next = lk[0] & lk[1];
          default: pin_out_next = 1'b0;
        endcase
      end
      2'b10: pin_out_next = cfg_reg[1].lsel ? fbp[0] : refp[0];
      2'b01: pin_out_next = cfg_reg[1].lsel ? fbp[1] : refp[1];
      default: begin
        if (fast) begin
          pin_oe_next = cfg_reg[0].cur | cfg_reg[1].cur;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_mux_pin_out <= 1'b0;
      status_mux_pin_oe <= 1'b1;
      pump_up <= 2'h0;
      pump_dn <= 2'h0;
      pump_hiz <= 2'h0;
      pump_current_level <= 4'h0;
      rf_in_hiz <= 2'h0;
      osc_enable <= 1'b1;
    end else if (ce) begin
      status_mux_pin_out <= pin_out_next;
      status_mux_pin_oe <= pin_oe_next;
      pump_up <= up_next;
      pump_dn <= dn_next;
      pump_hiz <= hiz;
      pump_current_level <= lvl_next;
      rf_in_hiz <= down;
      osc_enable <= ~(down[0] & down[1]);
    end
  end

  AST_PIN_OFF: assert property (
    fs == 2'b00 && ls == 2'b00
    |=> status_mux_pin_oe && !status_mux_pin_out)
    else $error("disabled status pin not driven low");
  AST_FAST: assert property (
    fast && cfg_reg[0].cur
    |=> status_mux_pin_oe && !status_mux_pin_out
        && pump_current_level[0] == `DSSPC_LVL_FAST)
    else $error("fast acquisition not applied");
  AST_CNT_RST: assert property (
    rst[0] |=> pump_hiz[0] && !pump_up[0] && !pump_dn[0])
    else $error("counter reset left pump driving");
  AST_OSC: assert property (
    down == 2'b11 |=> !osc_enable)
    else $error("oscillator on with both loops down");

  // APB slave: one wait state, unmapped addresses answer with an error
  logic pready_next, pslverr_next, acc;
  logic [31:0] prdata_next;
  logic [7:0] status;
  assign status = {osc_enable, sync_reg[6], pd_reg[1][1], pd_reg[0][1],
                   down, lock};
  always_comb begin
    acc = psel & penable & ~pready;
    pready_next = acc;
    pslverr_next = 1'b0;
    prdata_next = 32'h00000000;
    ctrl_next = ctrl_reg;
    if (acc) begin
      case (paddr)
        `DSSPC_ADDR_CTRL: prdata_next = {31'h00000000, ctrl_reg};
        `DSSPC_ADDR_STAT: prdata_next = {24'h000000, status};
        `DSSPC_ADDR_WORD: prdata_next = {10'h000, word_reg};
        default: pslverr_next = 1'b1;
      endcase
    end
    if (psel && penable && pready && pwrite
        && paddr == `DSSPC_ADDR_CTRL) begin
      ctrl_next = pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl_reg <= `DSSPC_RST_CTRL;
    end else if (ce) begin
      pready <= pready_next;
      pslverr <= pslverr_next;
      prdata <= prdata_next;
      ctrl_reg <= ctrl_next;
    end
  end

  AST_APB_WAIT: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not one wait state");
endmodule : dsspc_top
`default_nettype wire

// ===== dsspc_host.sv
// Host-side model of the three-wire programming link
`timescale 1ns/1ps
`default_nettype none
module dsspc_host #(
  parameter int HALF = 5
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [21:0] word,
  output logic             ser_data,
  output logic             ser_clk,
  output logic             load_strobe,
  output logic             busy
);
  logic [21:0] sr;
  logic [4:0]  nbit;
  int          tick;
  // Serial clock stands low between frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr          <= '0;
      nbit        <= '0;
      tick        <= 0;
      busy        <= 1'h0;
      ser_data    <= 1'h0;
      ser_clk     <= 1'h0;
      load_strobe <= 1'h0;
    end else if (!busy) begin
      if (start) begin
        sr       <= word;
        nbit     <= '0;
        tick     <= 0;
        busy     <= 1'h1;
        ser_data <= word[21];
      end
    end else if (tick < HALF - 1) begin
      tick <= tick + 1;
    end else begin
      tick <= 0;
      if (nbit < 5'h16) begin
        ser_clk <= ~ser_clk;
        if (ser_clk) begin
          sr   <= sr << 1;
          nbit <= nbit + 5'h01;
          // Released data line shows the inverse, never a stale bit
          ser_data <= (nbit == 5'h15) ? ~sr[21] : sr[20];
        end
      end else if (nbit == 5'h16) begin
        load_strobe <= 1'h1;
        nbit        <= 5'h17;
      end else if (nbit == 5'h17) begin
        nbit <= 5'h18;
      end else begin
        load_strobe <= 1'h0;
        busy        <= 1'h0;
      end
    end
  end
endmodule : dsspc_host
`default_nettype wire

// ===== dsspc_tb.sv
// Self-checking bench for the synthesizer control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic            er, sd, sc, ls, hstart, hbusy, pin_out, pin_oe;
  logic            osc, len, ce;
  logic            refi = 1'h0;
  logic [21:0]     hword, lastw;
  logic [1:0]      pup, pdn, phiz, rfz;
  logic [1:0]      vco = 2'h0;
  logic [1:0][1:0] lvl;
  logic [3:0]      cnt = 4'h0;
  int              mismatches, checked;
  // Open-drain pin pulled high when released
  wire             pin_lvl = pin_oe ? pin_out : 1'h1;

  dsspc_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ser_data(sd),
    .ser_clk(sc), .load_strobe(ls), .reference_input(refi), .vco_in(vco),
    .status_mux_pin_in(pin_lvl), .status_mux_pin_out(pin_out),
    .status_mux_pin_oe(pin_oe), .pump_up(pup), .pump_dn(pdn),
    .pump_hiz(phiz), .pump_current_level(lvl), .rf_in_hiz(rfz),
    .osc_enable(osc));
  dsspc_host #(.HALF(5)) host (.pclk(pclk), .presetn(presetn),
    .start(hstart), .word(hword), .ser_data(sd), .ser_clk(sc),
    .load_strobe(ls), .busy(hbusy));

  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cnt  <= cnt + 4'h1;
    refi <= cnt[2];
    vco  <= {cnt[0], cnt[1]};
  end

  task automatic tally_and_finish;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic fail;
    mismatches++;
    tally_and_finish();
  endtask : fail

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (n >= 50) fail();
  endtask : apb

  // Sends one word, then reads it back from the word register
  task automatic load(input logic [21:0] w);
    int n;
    @(posedge pclk);
    hword  <= w;
    hstart <= 1'h1;
    @(posedge pclk);
    hstart <= 1'h0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (hbusy !== 1'h0 && n < 1000);
    if (n >= 1000) fail();
    repeat (6) @(posedge pclk);
    if (len) lastw = w;
    apb(12'h008, 1'h0, 32'h0);
    `CHK(rd, {10'h000, lastw});
  endtask : load

  function automatic logic [21:0] rw(input logic [4:0] m, input logic [14:0] r,
                                     input logic [1:0] rt);
    return {m, r, rt};
  endfunction : rw

  function automatic logic [21:0] fw(input logic [1:0] m, input logic [10:0] b,
                                     input logic [6:0] a,
                                     input logic [1:0] rt);
    return {m, b, a, rt};
  endfunction : fw

  task automatic t_reset;
    `CHK(pin_oe, 1'h1);
    `CHK(pin_out, 1'h0);
    `CHK(rfz, 2'h0);
    `CHK(osc, 1'h1);
    apb(12'h000, 1'h0, 32'h0);
    `CHK(rd, 32'h1);
    apb(12'h004, 1'h0, 32'h0);
    `CHK(rd[7:2], 6'h20);
    $display("reset test done");
  endtask : t_reset

  task automatic t_routes;
    load(rw(5'h07, 15'h0005, 2'h1));
    `CHK(phiz, 2'h1);
    `CHK(lvl[0], 2'h1);
    load(rw(5'h05, 15'h7FFF, 2'h0));
    `CHK(phiz, 2'h3);
    `CHK(pup | pdn, 2'h0);
    `CHK(lvl[1], 2'h0);
    `CHK(lvl[0], 2'h1);
    load(fw(2'h1, 11'h7FF, 7'h40, 2'h2));
    load(fw(2'h0, 11'h003, 7'h03, 2'h3));
    `CHK(rfz, 2'h0);
    `CHK(pin_oe, 1'h1);
    $display("routing test done");
  endtask : t_routes

  task automatic t_refuse;
    apb(12'h000, 1'h1, 32'h0);
    len = 1'h0;
    load(rw(5'h00, 15'h0003, 2'h1));
    `CHK(phiz, 2'h3);
    apb(12'h000, 1'h1, 32'h1);
    len = 1'h1;
    apb(12'h010, 1'h1, 32'hFFFFFFFF);
    `CHK(er, 1'h1);
    $display("refusal test done");
  endtask : t_refuse

  task automatic t_pwdn;
    load(fw(2'h2, 11'h003, 7'h00, 2'h3));
    `CHK(rfz, 2'h1);
    `CHK(osc, 1'h1);
    load(fw(2'h2, 11'h003, 7'h00, 2'h2));
    `CHK(rfz, 2'h3);
    `CHK(osc, 1'h0);
    load(rw(5'h07, 15'h0009, 2'h1));
    load(fw(2'h0, 11'h003, 7'h00, 2'h3));
    `CHK(rfz, 2'h2);
    `CHK(osc, 1'h1);
    load(fw(2'h0, 11'h003, 7'h00, 2'h2));
    `CHK(rfz, 2'h0);
    $display("powerdown test done");
  endtask : t_pwdn

  task automatic t_sync;
    int n;
    load(rw(5'h01, 15'h0003, 2'h1));
    load(fw(2'h2, 11'h003, 7'h00, 2'h3));
    // Idle pump windows come only once per feedback cycle
    for (n = 0; n < 2000 && rfz[0] !== 1'h1; n++) @(posedge pclk);
    `CHK(rfz[0], 1'h1);
    load(fw(2'h0, 11'h003, 7'h00, 2'h3));
    `CHK(rfz[0], 1'h0);
    $display("deferred powerdown test done");
  endtask : t_sync

  task automatic t_fast;
    load(rw(5'h10, 15'h0003, 2'h0));
    load(rw(5'h12, 15'h0003, 2'h1));
    `CHK(pin_oe, 1'h1);
    `CHK(pin_out, 1'h0);
    `CHK(lvl[0], 2'h2);
    `CHK(lvl[1], 2'h0);
    load(rw(5'h10, 15'h0003, 2'h1));
    `CHK(pin_oe, 1'h0);
    `CHK(lvl[0], 2'h0);
    load(rw(5'h18, 15'h0003, 2'h1));
    `CHK(phiz, 2'h1);
    `CHK(pin_lvl, 1'h0);
    $display("fast mode test done");
  endtask : t_fast

  task automatic t_divout;
    int n;
    logic prev;
    load(rw(5'h00, 15'h0003, 2'h0));
    load(rw(5'h10, 15'h0005, 2'h1));
    n = 0;
    prev = pin_out;
    repeat (400) begin
      @(posedge pclk);
      if (pin_out === 1'h1 && prev === 1'h0) n++;
      prev = pin_out;
    end
    // Reference edges every 8 cycles, divided by 5
    `CHK(n >= 9 && n <= 11, 1'h1);
    // Clock enable low must freeze the divider output
    ce <= 1'h0;
    @(posedge pclk);
    prev = pin_out;
    n = 0;
    repeat (60) begin
      @(posedge pclk);
      if (pin_out !== prev) n++;
    end
    ce <= 1'h1;
    `CHK(n, 0);
    load(rw(5'h00, 15'h0005, 2'h1));
    `CHK(pin_oe, 1'h1);
    `CHK(pin_out, 1'h0);
    $display("divider output test done");
  endtask : t_divout

  initial begin
    pclk       = 1'h0;
    presetn    = 1'h0;
    psel       = 1'h0;
    penable    = 1'h0;
    pwrite     = 1'h0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    hstart     = 1'h0;
    hword      = 22'h0;
    ce         = 1'h1;
    len        = 1'h1;
    lastw      = 22'h0;
    mismatches = 0;
    checked    = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_routes();
    t_refuse();
    t_pwdn();
    t_sync();
    t_fast();
    t_divout();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
